// file: rdcl_pkg.sv
// Purpose: shared constants and types of the transmitter default-settings loader
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: one named constant per offset, field, reset value and setting figure

`default_nettype none

package rdcl_pkg;

    // ************************************************************
    // register map and fields
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_RXDLY = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_SHADOW = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_SHADOW_LAST = 12'h024;
    localparam int CTRL_PROTO_LSB = 0;
    localparam int CTRL_PROTO_W = 4;
    localparam int CTRL_START_BIT = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_BADP_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [3:0] CTRL_PROTO_RST = 4'h0;

    // ************************************************************
    // protocol codes, bit rates and target registers
    // ************************************************************
    localparam logic [3:0] PROTO_A106 = 4'h0;
    localparam logic [3:0] PROTO_A212 = 4'h1;
    localparam logic [3:0] PROTO_A424 = 4'h2;
    localparam logic [3:0] PROTO_A848 = 4'h3;
    localparam logic [3:0] PROTO_B106 = 4'h4;
    localparam logic [3:0] PROTO_B212 = 4'h5;
    localparam logic [3:0] PROTO_B424 = 4'h6;
    localparam logic [3:0] PROTO_B848 = 4'h7;
    localparam logic [3:0] PROTO_J212 = 4'h8;
    localparam logic [3:0] PROTO_COUNT = 4'h9;
    localparam logic [1:0] RATE_106 = 2'h0;
    localparam logic [1:0] RATE_212 = 2'h1;
    localparam logic [1:0] RATE_424 = 2'h2;
    localparam logic [1:0] RATE_848 = 2'h3;
    localparam int RXDLY_W = 16;
    localparam logic [2:0] TGT_TXCLK = 3'h0;
    localparam logic [2:0] TGT_LAST = 3'h5;

    // ************************************************************
    // default setting figures
    // ************************************************************
    localparam logic [31:0] VAL_ZERO = 32'h0000_0000;
    localparam logic [31:0] VAL_ANT = 32'h0000_0010;
    localparam logic [31:0] VAL_TXCLK_A106 = 32'h0000_0074;
    localparam logic [31:0] VAL_TXCLK_AHI = 32'h0000_0082;
    localparam logic [31:0] VAL_TXCLK_BLO = 32'h0000_008e;
    localparam logic [31:0] VAL_TXCLK_BHI = 32'h0000_078e;
    localparam logic [31:0] VAL_DMOD_ALO = 32'h0000_2350;
    localparam logic [31:0] VAL_DMOD_A424 = 32'h0000_0650;
    localparam logic [31:0] VAL_DMOD_A848 = 32'h0000_0150;
    localparam logic [31:0] VAL_USH_ALO = 32'h0000_0017;
    localparam logic [31:0] VAL_USH_A424 = 32'h0000_0005;
    localparam logic [31:0] VAL_USH_A848 = 32'h0000_0001;
    localparam logic [31:0] VAL_OSH_B424 = 32'h01fe_0013;
    localparam logic [31:0] VAL_OSH_B848 = 32'h007e_000d;
    localparam logic [31:0] VAL_TXCTL_ASTD = 32'h00db_cf43;
    localparam logic [31:0] VAL_TXCTL_A212 = 32'h0dbc_f043;
    localparam logic [31:0] VAL_TXCTL_A848 = 32'h00f9_ef45;
    localparam logic [31:0] VAL_TXCTL_B106 = 32'h003a_4756;
    localparam logic [31:0] VAL_TXCTL_B212 = 32'h0039_c746;
    localparam logic [31:0] VAL_TXCTL_B424 = 32'h0071_cf54;
    localparam logic [31:0] VAL_TXCTL_B848 = 32'h0069_af32;
    localparam logic [31:0] VAL_TXCTL_J212 = 32'h0039_e744;

    // ************************************************************
    // types
    // ************************************************************
    // element 0 clock ctl, 1 data mod, 2 undershoot, 3 overshoot, 4 tx ctl, 5 antenna
    typedef logic [5:0][31:0] rdcl_set_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_LOAD = 1'b1
    } rdcl_state_type;

    typedef struct packed {
        rdcl_state_type state;
        logic [3:0] loadProto;
        logic txWrValid;
        logic [2:0] txWrIndex;
        logic [31:0] txWrData;
        logic txHold;
        logic loadDone;
        logic [RXDLY_W-1:0] rxDelay;
        logic [3:0] proto;
        logic doneFlag;
        logic badFlag;
        rdcl_set_type shadow;
        logic awHeld;
        logic [ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rdcl_regs_type;

    localparam rdcl_regs_type REGS_RST = '0;

    function automatic rdcl_set_type rdcl_cfg_set(input logic [3:0] proto);
        rdcl_set_type s;
        case (proto)
            PROTO_A106: s = {VAL_ANT, VAL_TXCTL_ASTD, VAL_ZERO, VAL_USH_ALO,
                             VAL_DMOD_ALO, VAL_TXCLK_A106};
            PROTO_A212: s = {VAL_ANT, VAL_TXCTL_A212, VAL_ZERO, VAL_USH_ALO,
                             VAL_DMOD_ALO, VAL_TXCLK_AHI};
            PROTO_A424: s = {VAL_ANT, VAL_TXCTL_ASTD, VAL_ZERO, VAL_USH_A424,
                             VAL_DMOD_A424, VAL_TXCLK_AHI};
            PROTO_A848: s = {VAL_ANT, VAL_TXCTL_A848, VAL_ZERO, VAL_USH_A848,
                             VAL_DMOD_A848, VAL_TXCLK_AHI};
            PROTO_B106: s = {VAL_ANT, VAL_TXCTL_B106, VAL_ZERO, VAL_ZERO,
                             VAL_ZERO, VAL_TXCLK_BLO};
            PROTO_B212: s = {VAL_ANT, VAL_TXCTL_B212, VAL_ZERO, VAL_ZERO,
                             VAL_ZERO, VAL_TXCLK_BLO};
            PROTO_B424: s = {VAL_ANT, VAL_TXCTL_B424, VAL_OSH_B424, VAL_ZERO,
                             VAL_ZERO, VAL_TXCLK_BHI};
            PROTO_B848: s = {VAL_ANT, VAL_TXCTL_B848, VAL_OSH_B848, VAL_ZERO,
                             VAL_ZERO, VAL_TXCLK_BHI};
            PROTO_J212: s = {VAL_ANT, VAL_TXCTL_J212, VAL_ZERO, VAL_ZERO,
                             VAL_ZERO, VAL_TXCLK_BLO};
            default: s = '0;
        endcase
        return s;
    endfunction

    function automatic logic [1:0] rdcl_rate(input logic [3:0] proto);
        logic [1:0] r;
        case (proto)
            PROTO_A212, PROTO_B212, PROTO_J212: r = RATE_212;
            PROTO_A424, PROTO_B424: r = RATE_424;
            PROTO_A848, PROTO_B848: r = RATE_848;
            default: r = RATE_106;
        endcase
        return r;
    endfunction

endpackage

`default_nettype wire

// file: rdcl_tx_config_loader.sv
// Purpose: loads one protocol's default transmitter settings into six registers
// Assumes: single 50 MHz clock, AXI4-Lite master on the same clock
// Notes: writes go out one per accepted cycle on the tx write port

`timescale 1ns/1ps
`default_nettype none

// Operation
// - type A 106 loads its six figures
// - type A 212 loads its six figures
// - type A 424 loads its six figures
// - type A 848 loads its six figures
// - type B 106 loads its six figures
// - type B 212 loads its six figures
// - type B 424 loads its six figures
// - type B 848 loads its six figures
// - JIS mode 212 loads its six figures
// - reception start delay set without host help
module rdcl_tx_config_loader #(
    parameter logic [rdcl_pkg::RXDLY_W-1:0] RX_DELAY_106 = 16'h0040,
    parameter logic [rdcl_pkg::RXDLY_W-1:0] RX_DELAY_212 = 16'h0020,
    parameter logic [rdcl_pkg::RXDLY_W-1:0] RX_DELAY_424 = 16'h0010,
    parameter logic [rdcl_pkg::RXDLY_W-1:0] RX_DELAY_848 = 16'h0008
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [rdcl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rdcl_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic txWrValid,
    output logic [2:0] txWrIndex,
    output logic [31:0] txWrData,
    input wire logic txWrReady,
    output logic txHold,
    output logic loadDone,
    output logic [rdcl_pkg::RXDLY_W-1:0] rxStartDelay
);
    import rdcl_pkg::*;

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic rdcl_shadow_hit(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'b00) && (a >= OFS_SHADOW) && (a <= OFS_SHADOW_LAST);
    endfunction

    function automatic logic rdcl_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_RXDLY) ||
               rdcl_shadow_hit(a);
    endfunction

    function automatic logic [2:0] rdcl_shadow_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - OFS_SHADOW;
        return off[4:2];
    endfunction

    rdcl_regs_type q;
    rdcl_regs_type d;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic startReq;
        logic [2:0] nextIdx;
        rdcl_set_type startSet;
        rdcl_set_type loadSet;
        logic [RXDLY_W-1:0] rxSel;
        startReq = 1'b0;
        nextIdx = 3'h0;
        startSet = '0;
        loadSet = rdcl_cfg_set(q.loadProto);
        rxSel = RX_DELAY_106;
        d = q;
        d.loadDone = 1'b0;

        // the rate alone picks the reception start delay
        unique case (rdcl_rate(q.loadProto))
            RATE_106: rxSel = RX_DELAY_106;
            RATE_212: rxSel = RX_DELAY_212;
            RATE_424: rxSel = RX_DELAY_424;
            RATE_848: rxSel = RX_DELAY_848;
        endcase

        // write channels are taken independently, in either order
        if (s_axi_awvalid && q.awready) begin
            d.awHeld = 1'b1;
            d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.wHeld = 1'b1;
            d.wData = s_axi_wdata;
            d.wStrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.awHeld && q.wHeld && !q.bvalid) begin
            d.awHeld = 1'b0;
            d.wHeld = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            if (q.awAddr == OFS_CTRL) begin
                if (q.wStrb[0]) begin
                    d.proto = q.wData[CTRL_PROTO_LSB +: CTRL_PROTO_W];
                end
                startReq = q.wStrb[1] && q.wData[CTRL_START_BIT];
            end else if (q.awAddr == OFS_STATUS) begin
                // flags clear on one; a same-cycle set below still wins
                if (q.wStrb[0] && q.wData[STAT_DONE_BIT]) begin
                    d.doneFlag = 1'b0;
                end
                if (q.wStrb[0] && q.wData[STAT_BADP_BIT]) begin
                    d.badFlag = 1'b0;
                end
            end else if (!rdcl_mapped(q.awAddr)) begin
                d.bresp = RESP_SLVERR;
            end
        end

        // read channel answers the cycle after the address is taken
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rdata = '0;
            d.rresp = RESP_OKAY;
            if (s_axi_araddr == OFS_CTRL) begin
                d.rdata[CTRL_PROTO_LSB +: CTRL_PROTO_W] = q.proto;
            end else if (s_axi_araddr == OFS_STATUS) begin
                d.rdata[STAT_BUSY_BIT] = (q.state == ST_LOAD);
                d.rdata[STAT_DONE_BIT] = q.doneFlag;
                d.rdata[STAT_BADP_BIT] = q.badFlag;
            end else if (s_axi_araddr == OFS_RXDLY) begin
                d.rdata[RXDLY_W-1:0] = q.rxDelay;
            end else if (rdcl_shadow_hit(s_axi_araddr)) begin
                d.rdata = q.shadow[rdcl_shadow_idx(s_axi_araddr)];
            end else begin
                d.rresp = RESP_SLVERR;
            end
        end

        // ********************************************************
        // loader sequence
        // ********************************************************
        startSet = rdcl_cfg_set(d.proto);
        unique case (q.state)
            ST_IDLE: begin
                // a start while loading is ignored; the code is latched here
                if (startReq) begin
                    if (d.proto < PROTO_COUNT) begin
                        d.state = ST_LOAD;
                        d.loadProto = d.proto;
                        d.txWrValid = 1'b1;
                        d.txWrIndex = TGT_TXCLK;
                        d.txWrData = startSet[TGT_TXCLK];
                    end else begin
                        d.badFlag = 1'b1;
                    end
                end
            end
            ST_LOAD: begin
                if (q.txWrValid && txWrReady) begin
                    d.shadow[q.txWrIndex] = q.txWrData;
                    if (q.txWrIndex == TGT_LAST) begin
                        d.state = ST_IDLE;
                        d.txWrValid = 1'b0;
                        d.loadDone = 1'b1;
                        d.doneFlag = 1'b1;
                        d.rxDelay = rxSel;
                    end else begin
                        nextIdx = q.txWrIndex + 3'h1;
                        d.txWrIndex = nextIdx;
                        d.txWrData = loadSet[nextIdx];
                    end
                end
            end
        endcase

        // transmissions stay held off until the sixth write is taken
        d.txHold = (d.state == ST_LOAD);
        d.awready = !d.awHeld && !d.bvalid;
        d.wready = !d.wHeld && !d.bvalid;
        d.arready = !d.rvalid;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bresp = q.bresp;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_arready = q.arready;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rvalid = q.rvalid;
    assign txWrValid = q.txWrValid;
    assign txWrIndex = q.txWrIndex;
    assign txWrData = q.txWrData;
    assign txHold = q.txHold;
    assign loadDone = q.loadDone;
    assign rxStartDelay = q.rxDelay;

    // ************************************************************
    // checks
    // ************************************************************
    logic [3:0] wrCount;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrCount <= 4'h0;
        end else if (q.state == ST_IDLE) begin
            wrCount <= q.loadDone ? 4'h0 : wrCount;
        end else if (q.txWrValid && txWrReady) begin
            wrCount <= wrCount + 4'h1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    AST_A106_SET: assert property (
        q.loadDone && q.loadProto == PROTO_A106 |-> q.shadow == {VAL_ANT, VAL_TXCTL_ASTD,
        VAL_ZERO, VAL_USH_ALO, VAL_DMOD_ALO, VAL_TXCLK_A106})
        else $error("type A 106 settings wrong after load");
    AST_A212_SET: assert property (
        q.loadDone && q.loadProto == PROTO_A212 |-> q.shadow == {VAL_ANT, VAL_TXCTL_A212,
        VAL_ZERO, VAL_USH_ALO, VAL_DMOD_ALO, VAL_TXCLK_AHI})
        else $error("type A 212 settings wrong after load");
    AST_A424_SET: assert property (
        q.loadDone && q.loadProto == PROTO_A424 |-> q.shadow == {VAL_ANT, VAL_TXCTL_ASTD,
        VAL_ZERO, VAL_USH_A424, VAL_DMOD_A424, VAL_TXCLK_AHI})
        else $error("type A 424 settings wrong after load");
    AST_A848_SET: assert property (
        q.loadDone && q.loadProto == PROTO_A848 |-> q.shadow == {VAL_ANT, VAL_TXCTL_A848,
        VAL_ZERO, VAL_USH_A848, VAL_DMOD_A848, VAL_TXCLK_AHI})
        else $error("type A 848 settings wrong after load");
    AST_B106_SET: assert property (
        q.loadDone && q.loadProto == PROTO_B106 |-> q.shadow == {VAL_ANT, VAL_TXCTL_B106,
        VAL_ZERO, VAL_ZERO, VAL_ZERO, VAL_TXCLK_BLO})
        else $error("type B 106 settings wrong after load");
    AST_B212_SET: assert property (
        q.loadDone && q.loadProto == PROTO_B212 |-> q.shadow == {VAL_ANT, VAL_TXCTL_B212,
        VAL_ZERO, VAL_ZERO, VAL_ZERO, VAL_TXCLK_BLO})
        else $error("type B 212 settings wrong after load");
    AST_B424_SET: assert property (
        q.loadDone && q.loadProto == PROTO_B424 |-> q.shadow == {VAL_ANT, VAL_TXCTL_B424,
        VAL_OSH_B424, VAL_ZERO, VAL_ZERO, VAL_TXCLK_BHI})
        else $error("type B 424 settings wrong after load");
    AST_B848_SET: assert property (
        q.loadDone && q.loadProto == PROTO_B848 |-> q.shadow == {VAL_ANT, VAL_TXCTL_B848,
        VAL_OSH_B848, VAL_ZERO, VAL_ZERO, VAL_TXCLK_BHI})
        else $error("type B 848 settings wrong after load");
    AST_J212_SET: assert property (
        q.loadDone && q.loadProto == PROTO_J212 |-> q.shadow == {VAL_ANT, VAL_TXCTL_J212,
        VAL_ZERO, VAL_ZERO, VAL_ZERO, VAL_TXCLK_BLO})
        else $error("JIS 212 settings wrong after load");
    AST_RX_DELAY: assert property (
        q.loadDone |-> q.rxDelay == ((q.loadProto == PROTO_A106 || q.loadProto == PROTO_B106)
        ? RX_DELAY_106 : (q.loadProto == PROTO_A848 || q.loadProto == PROTO_B848)
        ? RX_DELAY_848 : (q.loadProto == PROTO_A424 || q.loadProto == PROTO_B424)
        ? RX_DELAY_424 : RX_DELAY_212))
        else $error("reception start delay not set for the rate");
    AST_SIX_WRITES: assert property (
        q.loadDone |-> wrCount == 4'h6 && !q.txHold && $past(q.txHold))
        else $error("completion without exactly six writes");
    AST_HOLD_WHILE_WRITING: assert property (
        q.txWrValid |-> q.txHold)
        else $error("tx write offered without hold");
    AST_OFFER_STABLE: assert property (
        q.txWrValid && !txWrReady |=> q.txWrValid && $stable(q.txWrIndex)
        && $stable(q.txWrData))
        else $error("tx write changed while stalled");

endmodule

`default_nettype wire

// file: rdcl_tx_sink.sv
// Purpose: transmitter datapath model taking the loader's settings writes
// Assumes: same clock as the loader, ready steered by the bench
// Notes: flags any change of an offered write before it is taken
`timescale 1ns/1ps
`default_nettype none
module rdcl_tx_sink (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic txWrValid,
    input wire logic [2:0] txWrIndex,
    input wire logic [31:0] txWrData,
    input wire logic readyMask,
    output logic txWrReady,
    output logic stableErr
);
    logic [31:0] txReg [0:5];
    logic offerWait_q;
    logic [35:0] offer_q;
    // ready comes straight from the bench so stalls can last any length
    assign txWrReady = readyMask;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            offerWait_q <= 1'b0;
            offer_q <= '0;
            stableErr <= 1'b0;
        end else begin
            if (offerWait_q && {txWrValid, txWrIndex, txWrData} !== offer_q) begin
                stableErr <= 1'b1;
            end
            offerWait_q <= txWrValid && !txWrReady;
            offer_q <= {txWrValid, txWrIndex, txWrData};
            if (txWrValid && txWrReady && txWrIndex < 3'd6) begin
                txReg[txWrIndex] <= txWrData;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench of the default-settings loader
// Assumes: AXI4-Lite master with bready and rready held high
// Notes: outputs are sampled at the falling edge, where they stand settled
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rdcl_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, txWrValid, txWrReady, txHold;
    logic loadDone, stableErr, readyMask = 1'b0, stall = 1'b0;
    logic [31:0] wdata = '0, rdata, txWrData;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp;
    logic [2:0] txWrIndex;
    logic [15:0] rxStartDelay;
    logic [31:0] rng = 32'h2d17c9a5;
    logic [35:0] txQ [$];
    logic [33:0] busQ [$];
    int n_fail = 0;
    int samples_checked = 0;
    localparam logic [31:0] EXP [0:8][0:5] = '{
        '{32'h74, 32'h2350, 32'h17, 32'h0, 32'hdbcf43, 32'h10},
        '{32'h82, 32'h2350, 32'h17, 32'h0, 32'hdbcf043, 32'h10},
        '{32'h82, 32'h650, 32'h5, 32'h0, 32'hdbcf43, 32'h10},
        '{32'h82, 32'h150, 32'h1, 32'h0, 32'hf9ef45, 32'h10},
        '{32'h8e, 32'h0, 32'h0, 32'h0, 32'h3a4756, 32'h10},
        '{32'h8e, 32'h0, 32'h0, 32'h0, 32'h39c746, 32'h10},
        '{32'h78e, 32'h0, 32'h0, 32'h1fe0013, 32'h71cf54, 32'h10},
        '{32'h78e, 32'h0, 32'h0, 32'h7e000d, 32'h69af32, 32'h10},
        '{32'h8e, 32'h0, 32'h0, 32'h0, 32'h39e744, 32'h10}};
    localparam logic [15:0] RXE [0:8] = '{16'h31, 16'h22, 16'h13, 16'h4, 16'h31, 16'h22,
        16'h13, 16'h4, 16'h22};
    rdcl_tx_config_loader #(.RX_DELAY_106(16'h0031), .RX_DELAY_212(16'h0022),
        .RX_DELAY_424(16'h0013), .RX_DELAY_848(16'h0004)) dut_u (
        .clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .txWrValid(txWrValid), .txWrIndex(txWrIndex), .txWrData(txWrData),
        .txWrReady(txWrReady), .txHold(txHold), .loadDone(loadDone),
        .rxStartDelay(rxStartDelay));
    rdcl_tx_sink sink_u (.clk(clk), .arst_n(arst_n), .txWrValid(txWrValid),
        .txWrIndex(txWrIndex), .txWrData(txWrData), .readyMask(readyMask),
        .txWrReady(txWrReady), .stableErr(stableErr));
    always #10 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    always @(posedge clk) begin
        rng <= xs(rng);
        readyMask <= !stall && rng[0];
    end
    task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    // ************************************************************
    // result watcher
    // ************************************************************
    always @(negedge clk) begin
        if (txWrValid === 1'b1 && txWrReady === 1'b1) begin
            if (txQ.size() == 0) chk("spare tx write", 0, 1);
            else chk("tx write", txQ.pop_front(), {txHold, txWrIndex, txWrData});
        end
        if (loadDone === 1'b1) chk("left at done", 0, {txHold, 32'(txQ.size())});
        if (bvalid === 1'b1 && bready === 1'b1) chk("bresp", busQ.pop_front(), {bresp, 32'h0});
        if (rvalid === 1'b1 && rready === 1'b1) chk("read", busQ.pop_front(), {rresp, rdata});
    end
    // ************************************************************
    // bus tasks, entered just after a rising edge
    // ************************************************************
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic ad, wd, ta, tw;
        busQ.push_back({er, 32'h0});
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        ad = 1'b0;
        wd = 1'b0;
        while (!(ad && wd)) begin
            @(negedge clk);
            ta = awready;
            tw = wready;
            @(posedge clk);
            if (ta === 1'b1) begin
                awvalid <= 1'b0;
                ad = 1'b1;
            end
            if (tw === 1'b1) begin
                wvalid <= 1'b0;
                wd = 1'b1;
            end
        end
        do @(negedge clk); while (bvalid !== 1'b1);
        @(posedge clk);
    endtask
    task automatic axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        busQ.push_back({er, d});
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        @(posedge clk);
    endtask
    task automatic load(input int p);
        for (int i = 0; i < 6; i++) txQ.push_back({1'b1, 3'(i), EXP[p][i]});
        axw(OFS_CTRL, 32'h100 | 32'(p), 4'h3, RESP_OKAY);
    endtask
    task automatic wait_done(input int p);
        do @(negedge clk); while (loadDone !== 1'b1);
        @(negedge clk);
        chk("done pulse", 0, loadDone);
        chk("rx delay", RXE[p], rxStartDelay);
        @(posedge clk);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("BAD watchdog expected finish seen hang");
        test_done();
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        axr(OFS_CTRL, 32'h0, RESP_OKAY);
        axr(OFS_STATUS, 32'h0, RESP_OKAY);
        axr(OFS_SHADOW_LAST, 32'h0, RESP_OKAY);
        axr(12'hf00, 32'h0, RESP_SLVERR);
        axr(12'h006, 32'h0, RESP_SLVERR);
        axw(12'hf00, 32'hffffffff, 4'hf, RESP_SLVERR);
        axw(OFS_RXDLY, 32'hffff, 4'hf, RESP_OKAY);
        axr(OFS_RXDLY, 32'h0, RESP_OKAY);
        // start bit without its byte strobe must not load
        axw(OFS_CTRL, 32'h103, 4'h1, RESP_OKAY);
        axr(OFS_CTRL, 32'h3, RESP_OKAY);
        axr(OFS_STATUS, 32'h0, RESP_OKAY);
        $display("test reset_map done");
        for (int p = 0; p < 9; p++) begin
            load(p);
            wait_done(p);
            axr(OFS_RXDLY, {16'h0, RXE[p]}, RESP_OKAY);
            axr(OFS_CTRL, 32'(p), RESP_OKAY);
            axr(OFS_STATUS, 32'h2, RESP_OKAY);
            for (int i = 0; i < 6; i++) begin
                axr(OFS_SHADOW + 12'(4 * i), EXP[p][i], RESP_OKAY);
            end
            axw(OFS_STATUS, 32'h2, 4'h1, RESP_OKAY);
        end
        $display("test all_protocols done");
        for (int c = 9; c < 16; c++) begin
            axw(OFS_CTRL, 32'h100 | 32'(c), 4'h3, RESP_OKAY);
            axr(OFS_STATUS, 32'h4, RESP_OKAY);
            axw(OFS_STATUS, 32'h4, 4'h1, RESP_OKAY);
        end
        $display("test bad_codes done");
        // datapath stalled so the second start lands while busy
        stall <= 1'b1;
        load(0);
        axr(OFS_STATUS, 32'h1, RESP_OKAY);
        axw(OFS_CTRL, 32'h104, 4'h3, RESP_OKAY);
        axr(OFS_STATUS, 32'h1, RESP_OKAY);
        stall <= 1'b0;
        wait_done(0);
        axr(OFS_SHADOW + 12'h10, EXP[0][4], RESP_OKAY);
        chk("offer stable", 0, stableErr);
        for (int i = 0; i < 6; i++) chk("sink reg", EXP[0][i], sink_u.txReg[i]);
        $display("test busy_start done");
        test_done();
    end
endmodule
`default_nettype wire
